/* File: adc_mux_and_control.sv */
// Reference and channel decode plus enable/start sequencing of the converter.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// How it works
// - Two reference bits pick supply, pin, internal.
// - Reference changes wait for conversion completion.
// - Channel changes wait for conversion completion.
// - Codes 0-7 route single-ended pins 0-7.
// - Ground, internal reference, temperature sensor codes.
// - Remaining code ranges reserved for differential/calibration.
// - Lowest bit picks 1x or 20x gain.
// - Top bit swaps differential pair polarity.
// - Full differential pair table decoded.
// - Same-pin calibration pairs on pins 0,3,7.
// - Enable powers converter; clearing aborts conversion.
// - Start bit starts one, or first free-running.
// - First conversion 25 cycles, later 13.
// - Start reads one while busy; zero ignored.
// - Done flag sets on completion; cleared by one.
// - Prescaler divides clock by 2 to 128.
// ----------------------------------------------------------------
module adc_mux_and_control
    import adc_ctrl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic vector_ack_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    output logic adc_power_out,
    output logic conv_start_out,
    output logic conv_done_out,
    output logic conv_first_out,
    output ref_route_type ref_route_out,
    output mux_route_type mux_route_out,
    output logic converter_clk_en_out
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic ref_route_type decode_ref(input logic [1:0] sel);
        ref_route_type r;
        r = '0;
        case (sel)
            REF_SUPPLY: r.supply_ref = 1'b1;
            REF_EXTERNAL: r.external_ref = 1'b1;
            REF_INTERNAL: r.internal_ref_on = 1'b1;
            default: r = '0;
        endcase
        return r;
    endfunction

    // Differential pair table indexed by the low five bits with the gain bit dropped.
    function automatic mux_route_type decode_mux(input logic [5:0] code);
        mux_route_type m;
        logic [7:0] pair;
        m = '0;
        pair = 8'h00;
        m.gain_20x = 1'b0;
        if (code[5:3] == 3'b000)
        begin
            m.pos_valid = 1'b1;
            m.pos_sel = {1'b0, code[2:0]};
        end
        else if (code == 6'b100000)
        begin
            m.pos_valid = 1'b1;
            m.pos_sel = SRC_AGND;
        end
        else if (code == 6'b100001)
        begin
            m.pos_valid = 1'b1;
            m.pos_sel = SRC_BANDGAP;
        end
        else if (code == 6'b100010)
        begin
            m.pos_valid = 1'b1;
            m.pos_sel = SRC_TEMP;
            m.temp_sensor_on = 1'b1;
        end
        else
        begin
            // Pair nibbles are {positive, negative}; top bit swaps them.
            case (code[4:1])
                4'h4: pair = 8'h01;
                4'h5: pair = 8'h03;
                4'h6: pair = 8'h12;
                4'h7: pair = 8'h13;
                4'h8: pair = 8'h23;
                4'h9: pair = 8'h34;
                4'hA: pair = 8'h35;
                4'hB: pair = 8'h36;
                4'hC: pair = 8'h37;
                4'hD: pair = 8'h45;
                4'hE: pair = 8'h56;
                4'hF: pair = 8'h67;
                default: pair = 8'h00;
            endcase
            if (code[5:3] == 3'b100)
            begin
                // Calibration: 100011 pin0, 10010x pin3, 10011x pin7.
                if (code[2:1] == 2'b01)
                    pair = 8'h00;
                else if (code[2:1] == 2'b10)
                    pair = 8'h33;
                else
                    pair = 8'h77;
                m.gain_20x = code[0] | (code[2:1] == 2'b01);
            end
            else
            begin
                if (code[5])
                    pair = {pair[3:0], pair[7:4]};
                m.gain_20x = code[BIT_GAIN];
            end
            m.pos_valid = !(code[5:1] == 5'b10000);
            m.neg_valid = m.pos_valid;
            m.pos_sel = pair[7:4];
            m.neg_sel = pair[3:0];
        end
        return m;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic enable;
    logic auto_trigger;
    logic done_flag;
    logic irq_enable;
    logic [2:0] prescale_sel;
    logic [7:0] ref_channel;
    logic [7:0] active_sel;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [6:0] prescale_cnt;
    logic [4:0] cycle_cnt;
    logic first_pending;
    logic start_req;
    conv_state_type state;
    logic tick;
    logic finish;
    logic wr_ctrl;

    assign wr_ctrl = write_in && addr_in == ADDR_CONTROL_STATUS;
    assign finish = state == ST_BUSY && tick && cycle_cnt == 5'd1;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // Division factor is 2 for codes 0 and 1, doubling to 128.
    logic [6:0] div_mask;
    assign div_mask = (prescale_sel == 3'd0) ? 7'h01 : PRESCALE_MAX >> (3'd7 - prescale_sel);

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            prescale_cnt <= 7'h00;
        else if (!enable)
            prescale_cnt <= 7'h00;
        else
            prescale_cnt <= prescale_cnt + 7'h01;
    end

    assign tick = enable && ((prescale_cnt & div_mask) == div_mask);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            enable <= 1'b0;
            auto_trigger <= 1'b0;
            irq_enable <= 1'b0;
            prescale_sel <= 3'h0;
        end
        else if (wr_ctrl)
        begin
            enable <= wdata_in[BIT_ENABLE];
            auto_trigger <= wdata_in[BIT_AUTO_TRIGGER];
            irq_enable <= wdata_in[BIT_IRQ_ENABLE];
            prescale_sel <= wdata_in[2:0];
        end
    end

    // Start writes of zero are ignored; request is held until the state is ST_BUSY or enable is cleared.
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            start_req <= 1'b0;
        else if (wr_ctrl && wdata_in[BIT_START] && wdata_in[BIT_ENABLE])
            start_req <= 1'b1;
        else if (!enable || (wr_ctrl && !wdata_in[BIT_ENABLE]) || state == ST_BUSY)
            start_req <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state <= ST_OFF;
            cycle_cnt <= 5'h00;
            first_pending <= 1'b1;
        end
        else if (wr_ctrl && !wdata_in[BIT_ENABLE])
        begin
            state <= ST_OFF;
            cycle_cnt <= 5'h00;
            first_pending <= 1'b1;
        end
        else
        begin
            case (state)
                ST_OFF:
                    if (enable)
                        state <= ST_IDLE;
                ST_IDLE:
                    if (start_req && tick)
                    begin
                        state <= ST_BUSY;
                        cycle_cnt <= first_pending ? FIRST_CONV_CYCLES : NORMAL_CONV_CYCLES;
                        first_pending <= 1'b0;
                    end
                ST_BUSY:
                    if (tick)
                    begin
                        if (cycle_cnt == 5'd1)
                        begin
                            // Free running reloads at once, leaving no idle cycle.
                            state <= auto_trigger ? ST_BUSY : ST_IDLE;
                            cycle_cnt <= NORMAL_CONV_CYCLES;
                        end
                        else
                            cycle_cnt <= cycle_cnt - 5'd1;
                    end
                default:
                    state <= ST_OFF;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Selections and shadow copy
    // ----------------------------------------------------------------
    // The written value is the shadow; the routing copy only moves when no conversion runs or one completes.
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            ref_channel <= RESET_REF_CHANNEL;
        else if (write_in && addr_in == ADDR_REF_CHANNEL)
            ref_channel <= wdata_in;
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            active_sel <= RESET_REF_CHANNEL;
        else if (state != ST_BUSY || finish)
            active_sel <= ref_channel;
    end

    // ----------------------------------------------------------------
    // Done flag and interrupt
    // ----------------------------------------------------------------
    // Completion wins over a simultaneous clear.
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            done_flag <= 1'b0;
        else if (finish)
            done_flag <= 1'b1;
        else if ((wr_ctrl && wdata_in[BIT_DONE_FLAG]) || vector_ack_in)
            done_flag <= 1'b0;
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            irq_status <= 8'h00;
        else if (finish)
            irq_status <= irq_status | 8'h01;
        else if (read_in && addr_in == ADDR_IRQ_STATUS)
            irq_status <= 8'h00;
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            irq_mask <= 8'h00;
        else if (write_in && addr_in == ADDR_IRQ_MASK)
            irq_mask <= {7'h00, wdata_in[0]};
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rdata_out <= 8'h00;
            irq_out <= 1'b0;
            adc_power_out <= 1'b0;
            conv_start_out <= 1'b0;
            conv_done_out <= 1'b0;
            conv_first_out <= 1'b0;
            ref_route_out <= '0;
            mux_route_out <= '0;
            converter_clk_en_out <= 1'b0;
        end
        else
        begin
            irq_out <= ((irq_status & irq_mask) != 8'h00) || (done_flag && irq_enable);
            adc_power_out <= enable;
            conv_start_out <= state == ST_IDLE && start_req && tick && !(wr_ctrl && !wdata_in[BIT_ENABLE]);
            conv_done_out <= finish && !(wr_ctrl && !wdata_in[BIT_ENABLE]);
            conv_first_out <= state == ST_BUSY && cycle_cnt > NORMAL_CONV_CYCLES;
            ref_route_out <= decode_ref(active_sel[BIT_REF_HI:BIT_REF_LO]);
            mux_route_out <= decode_mux(active_sel[5:0]);
            converter_clk_en_out <= tick;
            if (read_in)
            begin
                case (addr_in)
                    ADDR_CONTROL_STATUS: rdata_out <= {enable, state == ST_BUSY || start_req, auto_trigger,
                        done_flag, irq_enable, prescale_sel};
                    ADDR_REF_CHANNEL: rdata_out <= ref_channel;
                    ADDR_IRQ_STATUS: rdata_out <= irq_status;
                    ADDR_IRQ_MASK: rdata_out <= irq_mask;
                    default: rdata_out <= 8'h00;
                endcase
            end
            else
                rdata_out <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_abort_on_disable: assert property (@(posedge mclk_in) disable iff (reset_in)
        wr_ctrl && !wdata_in[BIT_ENABLE] |=> state == ST_OFF) else $error("disable did not abort");
    a_first_length: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_IDLE && start_req && tick && first_pending && !wr_ctrl |=> cycle_cnt == 5'd25)
        else $error("first conversion length wrong");
    a_normal_length: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_IDLE && start_req && tick && !first_pending && !wr_ctrl |=> cycle_cnt == 5'd13)
        else $error("normal conversion length wrong");
    a_done_sets: assert property (@(posedge mclk_in) disable iff (reset_in)
        finish |=> done_flag) else $error("done flag not set");
    a_done_clear: assert property (@(posedge mclk_in) disable iff (reset_in)
        !finish && wr_ctrl && wdata_in[BIT_DONE_FLAG] |=> !done_flag) else $error("done flag not cleared");
    a_sel_held_busy: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_BUSY && $past(state) == ST_BUSY && !$past(finish) |-> $stable(active_sel))
        else $error("routing changed mid conversion");
    a_tick_rate: assert property (@(posedge mclk_in) disable iff (reset_in)
        enable && prescale_sel == 3'd2 && $past(prescale_sel) == 3'd2 && tick |=> !tick ##1 !tick ##1 !tick)
        else $error("prescaler spacing wrong");
    a_temp_sensor: assert property (@(posedge mclk_in) disable iff (reset_in)
        active_sel[5:0] == 6'b100010 |=> mux_route_out.temp_sensor_on) else $error("temp sensor off");
    a_ref_internal: assert property (@(posedge mclk_in) disable iff (reset_in)
        active_sel[7:6] == 2'b10 |=> ref_route_out.internal_ref_on && !ref_route_out.supply_ref)
        else $error("reference decode wrong");
    c_conv_done: cover property (@(posedge mclk_in) disable iff (reset_in) finish);
    c_free_run: cover property (@(posedge mclk_in) disable iff (reset_in) finish && auto_trigger);
    c_abort: cover property (@(posedge mclk_in) disable iff (reset_in) state == ST_BUSY && wr_ctrl && !wdata_in[7]);
    c_deferred: cover property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_BUSY && write_in && addr_in == ADDR_REF_CHANNEL);

endmodule

/* File: adc_ctrl_pkg.sv */
// Package with register map, field layout and decode types of the converter control block.
package adc_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h6;
    localparam logic [2:0] ADDR_REF_CHANNEL = 3'h7;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h0;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h1;
    localparam logic [7:0] RESET_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] RESET_REF_CHANNEL = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE = 7;
    localparam int BIT_START = 6;
    localparam int BIT_AUTO_TRIGGER = 5;
    localparam int BIT_DONE_FLAG = 4;
    localparam int BIT_IRQ_ENABLE = 3;
    localparam int BIT_REF_HI = 7;
    localparam int BIT_REF_LO = 6;
    localparam int BIT_POLARITY = 5;
    localparam int BIT_GAIN = 0;

    // ----------------------------------------------------------------
    // Conversion timing in converter clock cycles
    // ----------------------------------------------------------------
    localparam logic [4:0] FIRST_CONV_CYCLES = 5'd25;
    localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
    localparam logic [6:0] PRESCALE_MAX = 7'h7F;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_IDLE = 3'b010,
        ST_BUSY = 3'b100
    } conv_state_type;

    typedef enum logic [1:0] {
        REF_SUPPLY = 2'b00,
        REF_EXTERNAL = 2'b01,
        REF_INTERNAL = 2'b10,
        REF_RESERVED = 2'b11
    } ref_sel_type;

    typedef struct packed {
        logic supply_ref;
        logic external_ref;
        logic internal_ref_on;
    } ref_route_type;

    typedef struct packed {
        logic pos_valid;
        logic [3:0] pos_sel;
        logic neg_valid;
        logic [3:0] neg_sel;
        logic gain_20x;
        logic temp_sensor_on;
    } mux_route_type;

    // Internal source codes for the positive input.
    localparam logic [3:0] SRC_AGND = 4'h8;
    localparam logic [3:0] SRC_BANDGAP = 4'h9;
    localparam logic [3:0] SRC_TEMP = 4'hA;

endpackage

/* File: adc_mux_and_control_tb_top.sv */
// Self-checking testbench of the converter mux and control block.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module adc_mux_and_control_tb_top;
    import adc_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic write_in = 1'b0;
    logic read_in = 1'b0;
    logic vector_ack_in = 1'b0;
    logic [7:0] rdata_out;
    logic irq_out;
    logic adc_power_out;
    logic conv_start_out;
    logic conv_done_out;
    logic conv_first_out;
    logic converter_clk_en_out;
    ref_route_type ref_route_out;
    mux_route_type mux_route_out;
    int fails = 0;
    int comparisons = 0;
    int ticks = 0;
    bit saw_first = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] expv;
    logic rd_seen = 1'b0;
    // Code, positive pin, negative pin of differential and calibration selections.
    logic [13:0] diff_tab [0:16] = '{{6'h08, 4'h0, 4'h1}, {6'h0A, 4'h0, 4'h3}, {6'h0C, 4'h1, 4'h2},
        {6'h0E, 4'h1, 4'h3}, {6'h10, 4'h2, 4'h3}, {6'h11, 4'h2, 4'h3}, {6'h12, 4'h3, 4'h4},
        {6'h18, 4'h3, 4'h7}, {6'h1E, 4'h6, 4'h7}, {6'h28, 4'h1, 4'h0}, {6'h2A, 4'h3, 4'h0},
        {6'h2D, 4'h2, 4'h1}, {6'h32, 4'h4, 4'h3}, {6'h3E, 4'h7, 4'h6}, {6'h23, 4'h0, 4'h0},
        {6'h24, 4'h3, 4'h3}, {6'h27, 4'h7, 4'h7}};

    always #4 mclk_in = ~mclk_in;

    adc_mux_and_control dut (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .write_in(write_in), .read_in(read_in), .vector_ack_in(vector_ack_in), .rdata_out(rdata_out),
        .irq_out(irq_out), .adc_power_out(adc_power_out), .conv_start_out(conv_start_out),
        .conv_done_out(conv_done_out), .conv_first_out(conv_first_out), .ref_route_out(ref_route_out),
        .mux_route_out(mux_route_out), .converter_clk_en_out(converter_clk_en_out));

    // ----------------------------------------------------------------
    // Watchers
    // ----------------------------------------------------------------
    // Read data stand only in the cycle after the strobe, so they are taken at the next edge.
    always @(posedge mclk_in)
    begin
        if (rd_seen)
        begin
            expv = exp_q.pop_front();
            `CHK(rdata_out, expv)
        end
        rd_seen = read_in;
    end

    // Non-blocking so the main process sees a settled count at the edge of the done pulse.
    always @(posedge mclk_in)
    begin
        if (conv_start_out === 1'b1)
            ticks <= 0;
        else if (converter_clk_en_out === 1'b1)
            ticks <= ticks + 1;
        if (conv_start_out === 1'b1)
            saw_first <= (conv_first_out === 1'b1);
        else if (conv_first_out === 1'b1)
            saw_first <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge mclk_in);
        write_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge mclk_in);
        read_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic wait_for(input bit done_sel, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(posedge mclk_in);
            if ((done_sel ? conv_done_out : conv_start_out) === 1'b1)
                return;
        end
        fails++;
        $display("[FAIL] t=%0t wait expired got=0 exp=1", $time);
        end_of_test();
    endtask

    task automatic count(input int sel, input int n, output int k);
        k = 0;
        repeat (n)
        begin
            @(posedge mclk_in);
            if ((sel == 0 ? conv_start_out : sel == 1 ? conv_done_out : converter_clk_en_out) === 1'b1)
                k++;
        end
    endtask

    task automatic route(input logic [7:0] v, input logic [3:0] ps, input logic nv, input logic [3:0] ns,
        input logic g, input logic t);
        wr(ADDR_REF_CHANNEL, v);
        repeat (2) @(posedge mclk_in);
        `CHK({mux_route_out.pos_valid, mux_route_out.pos_sel, mux_route_out.neg_valid, mux_route_out.gain_20x,
            mux_route_out.temp_sensor_on}, {1'b1, ps, nv, g, t})
        if (nv)
            `CHK(mux_route_out.neg_sel, ns)
    endtask

    // Long and short conversions differ by twelve ticks, so two ticks of slack are allowed below and one above.
    task automatic convert(input logic [7:0] ctl, input int lo, input bit mid);
        wr(ADDR_CONTROL_STATUS, ctl);
        wait_for(0, 600);
        if (mid)
        begin
            wr(ADDR_REF_CHANNEL, 8'h85);
            rd(ADDR_CONTROL_STATUS, 8'hC0);
            `CHK(mux_route_out.pos_sel, 4'h1)
            `CHK(ref_route_out, 3'b100)
        end
        wait_for(1, 2000);
        `CHK((ticks >= lo - 2 && ticks <= lo + 1), 1'b1)
        `CHK(saw_first, (lo == 25))
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        int k;
        logic [5:0] c;
        void'($urandom(32'h08AA));
        repeat (6) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        rd(ADDR_CONTROL_STATUS, RESET_CONTROL_STATUS);
        rd(ADDR_REF_CHANNEL, RESET_REF_CHANNEL);
        wr(3'h2, 8'hFF);
        rd(3'h2, 8'h00);
        $display("Test registers done");
        for (int r = 0; r < 4; r++)
        begin
            wr(ADDR_REF_CHANNEL, 8'(r << 6));
            repeat (2) @(posedge mclk_in);
            `CHK(ref_route_out, 3'(r == 3 ? 0 : 4 >> r))
        end
        for (int i = 0; i < 8; i++)
            route(8'(i), 4'(i), 1'b0, 4'h0, 1'b0, 1'b0);
        repeat (4)
        begin
            c = 6'($urandom % 8);
            route({2'($urandom % 3), c}, c[3:0], 1'b0, 4'h0, 1'b0, 1'b0);
        end
        route(8'h20, SRC_AGND, 1'b0, 4'h0, 1'b0, 1'b0);
        route(8'h21, SRC_BANDGAP, 1'b0, 4'h0, 1'b0, 1'b0);
        route(8'h22, SRC_TEMP, 1'b0, 4'h0, 1'b0, 1'b1);
        foreach (diff_tab[i])
            route({2'b00, diff_tab[i][13:8]}, diff_tab[i][7:4], 1'b1, diff_tab[i][3:0], diff_tab[i][8], 1'b0);
        $display("Test routing done");
        for (int p = 0; p < 8; p++)
        begin
            wr(ADDR_CONTROL_STATUS, 8'(8'h80 | p));
            repeat (260) @(posedge mclk_in);
            count(2, 1024, k);
            `CHK(k, (p < 2 ? 512 : 1024 >> p))
        end
        wr(ADDR_CONTROL_STATUS, 8'h00);
        $display("Test prescaler done");
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_REF_CHANNEL, 8'h01);
        convert(8'hC0, 25, 1'b1);
        repeat (3) @(posedge mclk_in);
        `CHK(mux_route_out.pos_sel, 4'h5)
        `CHK(ref_route_out, 3'b001)
        `CHK(irq_out, 1'b1)
        rd(ADDR_CONTROL_STATUS, 8'h90);
        rd(ADDR_IRQ_STATUS, 8'h01);
        @(posedge mclk_in);
        `CHK(irq_out, 1'b0)
        rd(ADDR_IRQ_STATUS, 8'h00);
        wr(ADDR_CONTROL_STATUS, 8'h90);
        rd(ADDR_CONTROL_STATUS, 8'h80);
        convert(8'hC0, 13, 1'b0);
        vector_ack_in <= 1'b1;
        @(posedge mclk_in);
        vector_ack_in <= 1'b0;
        @(posedge mclk_in);
        rd(ADDR_CONTROL_STATUS, 8'h80);
        rd(ADDR_IRQ_STATUS, 8'h01);
        $display("Test single conversions done");
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CONTROL_STATUS, 8'hE0);
        wait_for(1, 2000);
        wait_for(1, 2000);
        `CHK(irq_out, 1'b0)
        // Automatic restarts give no start pulse, so a completion marks the next conversion under way.
        wait_for(1, 2000);
        repeat (4) @(posedge mclk_in);
        wr(ADDR_CONTROL_STATUS, 8'h10);
        count(1, 200, k);
        `CHK(adc_power_out, 1'b0)
        `CHK(k, 0)
        rd(ADDR_CONTROL_STATUS, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h01);
        $display("Test free running and abort done");
        wr(ADDR_REF_CHANNEL, 8'h22);
        wr(ADDR_CONTROL_STATUS, 8'h80);
        count(0, 100, k);
        `CHK(adc_power_out, 1'b1)
        `CHK(k, 0)
        convert(8'hC0, 25, 1'b0);
        $display("Test restart done");
        end_of_test();
    end
endmodule
